// ==== design/tsq_defs.svh ====
// constants for the raster timing sequencer: offsets, reset values, timing
`ifndef TSQ_DEFS_SVH
`define TSQ_DEFS_SVH

// register indices; byte address is four times the index
`define TSQ_IDX_HALFSYNC    10'h021
`define TSQ_IDX_BACKPORCH   10'h022
`define TSQ_IDX_DISPLAY     10'h023
`define TSQ_IDX_SHORTDISP   10'h024
`define TSQ_IDX_BROADPULSE  10'h025
`define TSQ_IDX_VSYNC       10'h026
`define TSQ_IDX_VPREEQ      10'h027
`define TSQ_IDX_VPOSTEQ     10'h028
`define TSQ_IDX_VBLANK      10'h029
`define TSQ_IDX_VDISPLAY    10'h02A
`define TSQ_IDX_LINETIME    10'h02B
`define TSQ_IDX_LINESTART   10'h02C
`define TSQ_IDX_MEMINIT     10'h02D
`define TSQ_IDX_XFERDELAY   10'h02E
`define TSQ_NUM_PRM         14
`define TSQ_IDX_CTRLA       10'h060
`define TSQ_IDX_CTRLB       10'h070
`define TSQ_IDX_STATUS      10'h090
`define TSQ_IDX_MASK        10'h091

// reset values
`define TSQ_CTRLA_RST       24'h000000
`define TSQ_PRM_RST         16'h0000
`define TSQ_SYNC_IDLE       3'h1

// status bits: frame flyback entered, transfer issued
`define TSQ_STS_W           2
`define TSQ_STS_FRAME       0
`define TSQ_STS_XFER        1

// bus responses
`define TSQ_RESP_OKAY       2'h0
`define TSQ_RESP_SLVERR     2'h2
`define TSQ_RESP_DECERR     2'h3

// transfer strobe to request release, in aclk cycles
`define TSQ_REQ_HOLD        1

`endif

// ==== design/tsq_delay_line.sv ====
// programmable delay for the sync and blank outputs
`timescale 1ns/1ns
`include "tsq_defs.svh"

module tsq_delay_line #(
	parameter int DEPTH = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [2:0]        sel,
	input  tsq_pkg::tsq_sync_s     d,
	output tsq_pkg::tsq_sync_s     q
);
	import tsq_pkg::*;

	tsq_sync_s pipe_reg [DEPTH];
	tsq_sync_s q_reg;

	// shift chain, idle value is blanked with syncs high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe_reg[i] <= `TSQ_SYNC_IDLE;
			end
		end else begin
			pipe_reg[0] <= d;
			for (int i = 1; i < DEPTH; i++) begin
				pipe_reg[i] <= pipe_reg[i-1];
			end
		end
	end

	// tap select: sel extra cycles beyond the output flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_reg <= `TSQ_SYNC_IDLE;
		end else if (sel == 3'h0) begin
			q_reg <= d;
		end else begin
			q_reg <= pipe_reg[sel - 3'h1];
		end
	end

	assign q = q_reg;

	tap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$stable(sel) && sel == 3'h0 |=> q == $past(d))
		else $error("undelayed tap wrong");
	tap_three_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sel == 3'h3 [*5] |-> q == $past(d, 4))
		else $error("three cycle tap wrong");

endmodule

// ==== design/tsq_pkg.sv ====
// types shared by the raster timing sequencer modules
package tsq_pkg;

	typedef enum {V_PRE, V_SYNC, V_POST, V_BLANK, V_DISP} tsq_vst_e;

	// control register A, bit 0 at the bottom
	typedef struct packed {
		logic       cursor_off;
		logic [2:0] bpp;
		logic       delayed_samp;
		logic       interleave;
		logic [2:0] sync_delay;
		logic       dma_off;
		logic [1:0] vram_inc;
		logic       blank_off;
		logic       force_blank;
		logic       blank_sw;
		logic       blank_io;
		logic       pedestal;
		logic       video_only;
		logic       sep_sync;
		logic       plain_sync;
		logic       slave;
		logic       ccir;
		logic       interlace;
		logic       enable;
	} tsq_ctrl_s;

	typedef struct packed {
		logic csync_low;
		logic vsync_low;
		logic blank;
	} tsq_sync_s;

	typedef logic [15:0] tsq_param_t;

endpackage

// ==== design/tsq_timing.sv ====
// raster timing sequencer with AXI4-Lite register access
`timescale 1ns/1ns
`include "tsq_defs.svh"

module tsq_timing (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_hsync_n,
	input  wire logic        ext_vsync_n,
	output logic             csync_n_o,
	output logic             csync_oe_n,
	output logic             vsync_n_o,
	output logic             composite_blank,
	output logic             frame_flyback_flag,
	output logic             field_odd,
	output logic             bus_request_out,
	input  wire logic        bus_granted,
	output logic [1:0]       transfer_strobes,
	output logic [1:0]       shift_clock_gates,
	output logic             irq
);
	import tsq_pkg::*;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// parameter index test
	function automatic logic is_prm(input logic [9:0] idx);
		return idx >= `TSQ_IDX_HALFSYNC && idx <= `TSQ_IDX_XFERDELAY;
	endfunction

	tsq_ctrl_s                        ctrl_reg;
	logic [`TSQ_NUM_PRM-1:0][15:0]    prm_reg;
	logic [`TSQ_STS_W-1:0]            sts_reg;
	logic [`TSQ_STS_W-1:0]            mask_reg;
	logic [`TSQ_STS_W-1:0]            sts_ev;
	logic                             aw_have_reg;
	logic                             w_have_reg;
	logic [9:0]                       aw_idx_reg;
	logic [31:0]                      w_data_reg;
	logic [3:0]                       w_strb_reg;
	logic                             bvalid_reg;
	logic [1:0]                       bresp_reg;
	logic                             rvalid_reg;
	logic [1:0]                       rresp_reg;
	logic [31:0]                      rdata_reg;
	logic                             wr_go;
	logic                             rd_go;
	logic [9:0]                       ar_idx;
	logic                             sts_rd;

	tsq_param_t hs, bp, disp, broad, lt, meminit, tdelay;
	tsq_param_t vlimit, hs2, period, vnext, tpoint;
	tsq_vst_e   vstate_reg;
	tsq_param_t hpos_reg;
	tsq_param_t vcount_reg;
	logic       field_reg;
	logic       half_line, line_end, hbl, run;
	logic       hs_prev_reg, vs_prev_reg, hs_fall, vs_fall;
	tsq_sync_s  raw, dly;
	logic       bus_request_out_reg, xfer_reg, bank_reg, trig;
	logic [1:0] gates_reg;
	logic       flag_reg, act;

	// ---------------- register bus ----------------
	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready  = !w_have_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign wr_go         = aw_have_reg && w_have_reg && !bvalid_reg;
	assign rd_go         = s_axi_arvalid && !rvalid_reg;
	assign ar_idx        = s_axi_araddr[11:2];
	assign sts_rd        = rd_go && ar_idx == `TSQ_IDX_STATUS;

	// address and data latches, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_idx_reg  <= 10'h000;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_have_reg) begin
				aw_have_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[11:2];
			end else if (wr_go) begin
				aw_have_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_reg) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_reg <= 1'b0;
			end
		end
	end

	// register writes and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg   <= `TSQ_CTRLA_RST;
			prm_reg    <= '0;
			mask_reg   <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= `TSQ_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= `TSQ_RESP_OKAY;
			if (is_prm(aw_idx_reg)) begin
				if (ctrl_reg.enable) begin
					bresp_reg <= `TSQ_RESP_SLVERR;
				end else begin
					// screen description loaded by the host while stopped
					prm_reg[aw_idx_reg - `TSQ_IDX_HALFSYNC] <=
						16'(merge({16'h0000, prm_reg[aw_idx_reg - `TSQ_IDX_HALFSYNC]},
						w_data_reg, w_strb_reg));
				end
			end else if (aw_idx_reg == `TSQ_IDX_CTRLA) begin
				ctrl_reg <= 24'(merge({8'h00, ctrl_reg}, w_data_reg, w_strb_reg));
			end else if (aw_idx_reg == `TSQ_IDX_MASK) begin
				mask_reg <= `TSQ_STS_W'(merge({30'h0, mask_reg}, w_data_reg, w_strb_reg));
			end else if (aw_idx_reg != `TSQ_IDX_CTRLB && aw_idx_reg != `TSQ_IDX_STATUS) begin
				bresp_reg <= `TSQ_RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read data and read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `TSQ_RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else if (rd_go) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= `TSQ_RESP_OKAY;
			rdata_reg  <= 32'h00000000;
			if (is_prm(ar_idx)) begin
				if (ctrl_reg.enable) rresp_reg <= `TSQ_RESP_SLVERR;
				else rdata_reg <= {16'h0000, prm_reg[ar_idx - `TSQ_IDX_HALFSYNC]};
			end else if (ar_idx == `TSQ_IDX_CTRLA) begin
				rdata_reg <= {8'h00, ctrl_reg};
			end else if (ar_idx == `TSQ_IDX_STATUS) begin
				rdata_reg <= {30'h0, sts_reg};
			end else if (ar_idx == `TSQ_IDX_MASK) begin
				rdata_reg <= {30'h0, mask_reg};
			end else if (ar_idx != `TSQ_IDX_CTRLB) begin
				rresp_reg <= `TSQ_RESP_DECERR;
			end
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// sticky status, cleared by read, a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) sts_reg <= '0;
		else sts_reg <= (sts_reg & ~{`TSQ_STS_W{sts_rd}}) | sts_ev;
	end

	assign irq = |(sts_reg & mask_reg);

	// ---------------- timing sequencer ----------------
	assign run     = ctrl_reg.enable;
	assign hs      = prm_reg[`TSQ_IDX_HALFSYNC - `TSQ_IDX_HALFSYNC];
	assign bp      = prm_reg[`TSQ_IDX_BACKPORCH - `TSQ_IDX_HALFSYNC];
	assign disp    = prm_reg[`TSQ_IDX_DISPLAY - `TSQ_IDX_HALFSYNC];
	assign broad   = prm_reg[`TSQ_IDX_BROADPULSE - `TSQ_IDX_HALFSYNC];
	assign lt      = prm_reg[`TSQ_IDX_LINETIME - `TSQ_IDX_HALFSYNC];
	assign meminit = prm_reg[`TSQ_IDX_MEMINIT - `TSQ_IDX_HALFSYNC];
	assign tdelay  = prm_reg[`TSQ_IDX_XFERDELAY - `TSQ_IDX_HALFSYNC];
	assign hs2     = {hs[14:0], 1'b0};

	// vertical limit of the current phase, in half lines
	always_comb begin
		unique case (vstate_reg)
			V_PRE:   vlimit = prm_reg[`TSQ_IDX_VPREEQ - `TSQ_IDX_HALFSYNC];
			V_SYNC:  vlimit = prm_reg[`TSQ_IDX_VSYNC - `TSQ_IDX_HALFSYNC];
			V_POST:  vlimit = prm_reg[`TSQ_IDX_VPOSTEQ - `TSQ_IDX_HALFSYNC];
			V_BLANK: vlimit = prm_reg[`TSQ_IDX_VBLANK - `TSQ_IDX_HALFSYNC];
			V_DISP:  vlimit = prm_reg[`TSQ_IDX_VDISPLAY - `TSQ_IDX_HALFSYNC];
		endcase
	end

	// half-line periods in the pre-equalising, sync and post-equalising phases and the odd last line of an interlaced field
	assign half_line = vstate_reg inside {V_PRE, V_SYNC, V_POST} ||
		(vstate_reg == V_DISP && ctrl_reg.interlace && vcount_reg + 16'h0001 == vlimit);
	assign period    = half_line ? {1'b0, lt[15:1]} : lt;
	assign line_end  = hpos_reg >= period - 16'h0001;
	assign vnext     = vcount_reg + (half_line ? 16'h0001 : 16'h0002);
	assign hs_fall   = hs_prev_reg && !ext_hsync_n;
	assign vs_fall   = vs_prev_reg && !ext_vsync_n;

	// external sync edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_prev_reg <= 1'b1;
			vs_prev_reg <= 1'b1;
		end else begin
			hs_prev_reg <= ext_hsync_n;
			vs_prev_reg <= ext_vsync_n;
		end
	end

	// horizontal position, one screen unit per clock
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) hpos_reg <= 16'h0000;
		else if (ctrl_reg.slave && hs_fall) hpos_reg <= 16'h0000;
		else if (line_end) hpos_reg <= 16'h0000;
		else hpos_reg <= hpos_reg + 16'h0001;
	end

	// vertical phase walk in half lines
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			vstate_reg <= V_PRE;
			vcount_reg <= 16'h0000;
			field_reg  <= 1'b0;
		end else if (ctrl_reg.slave && vs_fall) begin
			vstate_reg <= V_PRE;
			vcount_reg <= 16'h0000;
			field_reg  <= !field_reg;
		end else if (line_end) begin
			if (vnext >= vlimit) begin
				vcount_reg <= 16'h0000;
				unique case (vstate_reg)
					V_PRE:   vstate_reg <= V_SYNC;
					V_SYNC:  vstate_reg <= V_POST;
					V_POST:  vstate_reg <= V_BLANK;
					V_BLANK: vstate_reg <= V_DISP;
					V_DISP: begin
						vstate_reg <= V_PRE;
						field_reg  <= ctrl_reg.interlace && !field_reg;
					end
				endcase
			end else begin
				vcount_reg <= vnext;
			end
		end
	end

	assign field_odd = field_reg ^ ctrl_reg.ccir;
	assign sts_ev    = {xfer_reg, run && line_end && vstate_reg == V_DISP && vnext >= vlimit};

	// horizontal flyback of a full line
	assign hbl = hpos_reg < hs2 + bp || hpos_reg >= hs2 + bp + disp;

	// raw sync and blank waveforms
	always_comb begin
		raw.vsync_low = run && vstate_reg == V_SYNC;
		if (!run) raw.csync_low = 1'b0;
		else if (ctrl_reg.sep_sync) raw.csync_low = hpos_reg < hs2;
		else begin
			unique case (vstate_reg)
				V_PRE, V_POST: raw.csync_low = hpos_reg < hs;
				V_SYNC: raw.csync_low = ctrl_reg.plain_sync || hpos_reg < broad;
				V_BLANK, V_DISP: raw.csync_low = hpos_reg < hs2;
			endcase
		end
		raw.blank = !run || ctrl_reg.force_blank ||
			(!ctrl_reg.blank_off && (vstate_reg != V_DISP || hbl));
	end

	tsq_delay_line #(
		.DEPTH (8)
	) u_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sel     (ctrl_reg.sync_delay),
		.d       (raw),
		.q       (dly)
	);

	// pins; in slave mode the sync pin is released
	assign csync_n_o       = !dly.csync_low;
	assign vsync_n_o       = !dly.vsync_low;
	assign csync_oe_n      = ctrl_reg.slave;
	assign composite_blank = dly.blank;

	// frame flyback flag
	always_ff @(posedge aclk) begin
		if (!aresetn) flag_reg <= 1'b1;
		else flag_reg <= !run || vstate_reg != V_DISP;
	end

	assign frame_flyback_flag = flag_reg;

	// reload point: meminit before the first line, back porch minus delay after
	assign tpoint = vstate_reg == V_BLANK ? meminit : hs2 + bp - tdelay;
	assign trig   = run && !ctrl_reg.dma_off && !half_line && hpos_reg == tpoint &&
		(vstate_reg == V_DISP || (vstate_reg == V_BLANK && vnext >= vlimit));

	// bus request, transfer strobe, bank toggle
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			bus_request_out_reg <= 1'b0;
			xfer_reg   <= 1'b0;
			bank_reg   <= 1'b0;
		end else begin
			xfer_reg <= bus_request_out_reg && bus_granted && !xfer_reg;
			if (xfer_reg) begin
				bus_request_out_reg <= 1'b0;
				bank_reg   <= !bank_reg;
			end else if (trig) begin
				bus_request_out_reg <= 1'b1;
			end
		end
	end

	assign bus_request_out  = bus_request_out_reg;
	assign transfer_strobes = {2{xfer_reg}} & (bank_reg ? 2'b10 : 2'b01);

	// shift clocks run on the last loaded bank during visible pixels
	assign act = run && vstate_reg == V_DISP && !hbl;

	always_ff @(posedge aclk) begin
		if (!aresetn) gates_reg <= 2'h0;
		else gates_reg <= {2{act}} & (bank_reg ? 2'b01 : 2'b10);
	end

	assign shift_clock_gates = gates_reg;

	// ---------------- checks ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	idle_blanked_a: assert property (!run |-> raw.blank && !bus_request_out)
		else $error("stopped sequencer not blanked");
	req_release_a: assert property (|transfer_strobes |-> bus_request_out ##`TSQ_REQ_HOLD !bus_request_out)
		else $error("bus request not released after strobe");
	xfer_grant_a: assert property ($rose(|transfer_strobes) |-> $past(bus_granted && bus_request_out))
		else $error("strobe without grant");
	flyback_flag_a: assert property (vstate_reg != V_DISP |=> frame_flyback_flag)
		else $error("flyback flag low in flyback");
	blank_cover_a: assert property (run && !ctrl_reg.blank_off && (vstate_reg != V_DISP || hbl) |-> raw.blank)
		else $error("blank low in flyback");
	sync_pair_a: assert property (run && !ctrl_reg.sep_sync && !half_line && hpos_reg < hs2 |-> raw.csync_low)
		else $error("line sync shorter than two half syncs");
	half_step_a: assert property (run && line_end && !ctrl_reg.slave && vnext < vlimit |=>
		vcount_reg == $past(vcount_reg) + ($past(half_line) ? 16'h0001 : 16'h0002))
		else $error("vertical count step wrong");
	half_period_a: assert property (run && line_end && half_line |-> hpos_reg >= {1'b0, lt[15:1]} - 16'h0001)
		else $error("half line period wrong");
	slave_release_a: assert property (ctrl_reg.slave |-> csync_oe_n)
		else $error("sync driven in slave mode");
	prm_lock_a: assert property (wr_go && is_prm(aw_idx_reg) && run |=> $stable(prm_reg) && bresp_reg == `TSQ_RESP_SLVERR)
		else $error("parameter changed while running");
	gate_run_a: assert property (act |=> |shift_clock_gates)
		else $error("shift clock not started");

endmodule

// ==== verification/test_tsq_timing.sv ====
// self-checking bench for the raster timing sequencer
`timescale 1ns/1ns
`include "tsq_defs.svh"

module test_tsq_timing;
	import tsq_pkg::*;

	typedef struct {
		logic [9:0]  idx;
		logic [31:0] wd;
		logic [31:0] rd;
	} tsq_row_s;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] aw = 12'h0;
	logic [11:0] ar = 12'h0;
	logic [31:0] wd = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        bry = 1'b0;
	logic        arv = 1'b0;
	logic        rry = 1'b0;
	logic        slow = 1'b0;
	logic        ehs = 1'b1;
	logic        evs = 1'b1;
	logic [3:0]  ws = 4'hF;
	logic        awr, wrd, bvalid, arr, rvalid, csn, csoe, vsn, blank, fly, breq, grant, irq, fo;
	logic [1:0]  bresp, rresp, xs, gates;
	logic [31:0] rdata;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	logic [1:0]  r, s0, s1;
	logic [31:0] d;
	int          n, fh, fl, bl, cl, gl, vl;

	// host writes the complete screen description, then stray and control words
	tsq_row_s rows [17] = '{
		'{`TSQ_IDX_HALFSYNC, 32'hABCD0002, 32'h2}, '{`TSQ_IDX_BACKPORCH, 32'h12, 32'h12},
		'{`TSQ_IDX_DISPLAY, 32'h14, 32'h14}, '{`TSQ_IDX_SHORTDISP, 32'h4, 32'h4},
		'{`TSQ_IDX_BROADPULSE, 32'h1A, 32'h1A}, '{`TSQ_IDX_VSYNC, 32'h3, 32'h3},
		'{`TSQ_IDX_VPREEQ, 32'h3, 32'h3}, '{`TSQ_IDX_VPOSTEQ, 32'h3, 32'h3},
		'{`TSQ_IDX_VBLANK, 32'h4, 32'h4}, '{`TSQ_IDX_VDISPLAY, 32'h8, 32'h8},
		'{`TSQ_IDX_LINETIME, 32'h3C, 32'h3C}, '{`TSQ_IDX_LINESTART, 32'h2, 32'h2},
		'{`TSQ_IDX_MEMINIT, 32'hA, 32'hA}, '{`TSQ_IDX_XFERDELAY, 32'h3, 32'h3},
		'{`TSQ_IDX_CTRLA, 32'hFF000000, 32'h0}, '{`TSQ_IDX_CTRLB, 32'h5, 32'h0},
		'{`TSQ_IDX_MASK, 32'h1, 32'h1}
	};

	tsq_timing uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bry),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rry),
		.ext_hsync_n(ehs), .ext_vsync_n(evs),
		.csync_n_o(csn), .csync_oe_n(csoe), .vsync_n_o(vsn), .composite_blank(blank),
		.frame_flyback_flag(fly), .field_odd(fo), .bus_request_out(breq), .bus_granted(grant),
		.transfer_strobes(xs), .shift_clock_gates(gates), .irq(irq)
	);

	tsq_vram_model vram (
		.aclk(aclk), .aresetn(aresetn), .bus_request_out(breq),
		.transfer_strobes(xs), .slow(slow), .bus_granted(grant)
	);

	// 50 MHz clock
	always #10 aclk = ~aclk;

	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		aw <= {i, 2'b00};
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bry <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] i, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		ar <= {i, 2'b00};
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
		end while (!rvalid);
		v = rdata;
		rs = rresp;
		rry <= 1'b0;
	endtask

	// waits for one reload strobe and checks the request release after it
	task automatic xfer(output logic [1:0] st);
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while (xs == 2'h0 && n < 3000);
		st = xs;
		chk("req_at_strobe", 1, breq);
		@(posedge aclk);
		#1;
		chk("req_released", 0, breq);
		chk("strobe_width", 0, xs);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		chk("blank_rst", 1, blank);
		chk("flyback_rst", 1, fly);
		chk("req_rst", 0, breq);
		chk("strobe_rst", 0, xs);
		chk("gates_rst", 0, gates);
		chk("sync_rst", 3'h6, {csn, vsn, csoe});
		chk("irq_rst", 0, irq);
		foreach (rows[k]) begin
			wr(rows[k].idx, rows[k].wd, r);
			chk("wresp", `TSQ_RESP_OKAY, r);
			rd(rows[k].idx, d, r);
			chk("rdata", rows[k].rd, d);
			chk("rresp", `TSQ_RESP_OKAY, r);
		end
		// byte lane merge on a spare parameter
		ws <= 4'h2;
		wr(`TSQ_IDX_SHORTDISP, 32'h00001100, r);
		ws <= 4'hF;
		rd(`TSQ_IDX_SHORTDISP, d, r);
		chk("rdata_lane", 32'h1104, d);
		// unmapped place
		wr(10'h050, 32'h1, r);
		chk("wresp_unmapped", `TSQ_RESP_DECERR, r);
		rd(10'h050, d, r);
		chk("rdata_unmapped", 0, d);
		chk("rresp_unmapped", `TSQ_RESP_DECERR, r);
		// start the sequencer, then parameters are locked
		wr(`TSQ_IDX_CTRLA, 32'h18001, r);
		wr(`TSQ_IDX_LINETIME, 32'h40, r);
		chk("wresp_locked", `TSQ_RESP_SLVERR, r);
		rd(`TSQ_IDX_LINETIME, d, r);
		chk("rdata_locked", 0, d);
		chk("rresp_locked", `TSQ_RESP_SLVERR, r);
		// prompt grant, then stalled grant; banks alternate
		xfer(s0);
		slow <= 1'b1;
		xfer(s1);
		chk("bank_alt", 3, s0 ^ s1);
		// watch more than one whole frame
		fh = 0;
		fl = 0;
		bl = 0;
		cl = 0;
		gl = 0;
		vl = 0;
		repeat (1500) begin
			@(posedge aclk);
			#1;
			fh += fly;
			fl += !fly;
			bl += !blank;
			cl += !csn;
			gl += (gates != 2'h0);
			vl += !vsn;
		end
		chk("gates_seen", 1, gl > 0);
		chk("vsync_seen", 1, vl > 0);
		chk("field_prog", 0, fo);
		chk("flyback_seen", 1, fh > 0 && fl > 0);
		chk("display_seen", 1, bl > 0);
		chk("csync_seen", 1, cl > 0);
		// frame event interrupt: raise, clear by read, mask
		n = 0;
		while (!irq && n < 2000) begin
			@(posedge aclk);
			#1;
			n++;
		end
		chk("irq_up", 1, irq);
		rd(`TSQ_IDX_STATUS, d, r);
		chk("status_frame", 1, d[`TSQ_STS_FRAME]);
		wr(`TSQ_IDX_MASK, 32'h0, r);
		@(posedge aclk);
		#1;
		chk("irq_masked", 0, irq);
		// slave mode: sync pin released, external frame sync restarts the field
		wr(`TSQ_IDX_CTRLA, 32'h18009, r);
		chk("oe_slave", 1, csoe);
		n = 0;
		while (fly && n < 2000) begin
			@(posedge aclk);
			#1;
			n++;
		end
		@(posedge aclk);
		ehs <= 1'b0;
		evs <= 1'b0;
		@(posedge aclk);
		ehs <= 1'b1;
		evs <= 1'b1;
		@(posedge aclk);
		#1;
		chk("flyback_slave", 1, fly);
		chk("field_slave", 1, fo);
		end_sim();
	end
endmodule

// ==== verification/tsq_vram_model.sv ====
// video RAM side model: grants shift reload requests promptly or after a stall
`timescale 1ns/1ns

module tsq_vram_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       bus_request_out,
	input  wire logic [1:0] transfer_strobes,
	input  wire logic       slow,
	output logic            bus_granted
);
	logic [1:0] stall_reg;

	// grant is low from time zero, before the first reset edge
	initial begin
		bus_granted = 1'b0;
		stall_reg = 2'h0;
	end

	// grant a pending request, withdraw it as soon as the strobe shows
	always @(posedge aclk) begin
		if (!aresetn || !bus_request_out || transfer_strobes != 2'h0) begin
			bus_granted <= 1'b0;
			stall_reg <= 2'h0;
		end else if (!slow || stall_reg == 2'h3) begin
			bus_granted <= 1'b1;
		end else begin
			stall_reg <= stall_reg + 2'h1;
		end
	end
endmodule
